// >>> verilog/t1ad_alarm_top.sv
// t1 receive alarm and status detection with its status/control registers.
// assumes rx line bits and framer indications arrive on clk with a bit strobe.
//
// Notes on behaviour
// - loop-down flag set while repeating 001 code is received
// - tx clock loss flagged after one channel time without tx clock edges
// - tx clock loss pin driven high when enabled by control bit
// - blue alarm set when five or fewer zeros arrive in 3 ms
// - blue alarm cleared when six or more zeros arrive in 3 ms
// - bit-2 yellow set when bit 2 zero in 254 of 256 channels
// - bit-2 yellow cleared when bit 2 zero in under 254 of 256
// - f12 yellow set after two ones, cleared after two zeros
// - esf yellow set after sixteen consecutive 00ff data link words
// - esf yellow cleared when at most fourteen of sixteen words match
// - red alarm set after 192 consecutive zeros
// - red alarm cleared on 14 ones in 112 bits from first one
// - loop codes detected framed or unframed at 1e-2 error rate
// - loop code detector integrates over about 48 ms
// - remote loopback returns received line data unchanged, violations kept
// - flags latch until cleared by a status write and reassert while event persists
// - mask write: ones update read copy and clear, zeros hold
// - unmasked flags drive the interrupt output
`timescale 1ns/1ps
`default_nettype none
module t1ad_alarm_top
   import t1ad_pkg::*;
#(
   parameter int unsigned BLUE_CYC = BLUE_WIN_CYC,
   parameter int unsigned LOOP_CYC = LOOP_INT_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // recovered receive line, strobed per bit
   input  wire logic       rx_bit_en,
   input  wire logic       rx_line_pos,
   input  wire logic       rx_line_neg,
   // transmit line clock pin
   input  wire logic       tx_line_clock,
   // transmit data from the transmitter
   input  wire logic       tx_data_pos,
   input  wire logic       tx_data_neg,
   // framer indications
   input  wire t1ad_frm_t  frm,
   // parallel host port
   input  wire t1ad_host_t host,
   output logic [7:0]      rdata,
   // line out and pins
   output logic            line_tx_pos,
   output logic            line_tx_neg,
   output logic            tx_clock_loss_pin,
   output logic            irq_out_one
);
   // ---------------- registers ----------------
   logic [7:0] latch_ff, nxt_latch;
   logic [7:0] copy_ff, nxt_copy;
   logic [7:0] irq_mask_one_ff, nxt_irq_mask_one;
   logic [7:0] common_control_one_ff, nxt_common_control_one;
   logic [7:0] common_control_two_ff, nxt_common_control_two;
   logic [7:0] rx_control_two_ff, nxt_rx_control_two;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [7:0] events;
   logic       wr_stat;

   // ---------------- line data ----------------
   logic rx_one;
   logic rx_zero;
   assign rx_one  = rx_line_pos | rx_line_neg;
   assign rx_zero = ~rx_one;

   // ---------------- loop codes ----------------
   logic loop_up_det;
   logic loop_dn_det;

   t1ad_loop_det #(.P(LOOP_UP_LEN), .INT_CYC(LOOP_CYC)) u_loop_up (
      .clk    (clk),
      .srst   (srst),
      .bit_en (rx_bit_en),
      .bit_in (rx_one),
      .det    (loop_up_det)
   );

   t1ad_loop_det #(.P(LOOP_DN_LEN), .INT_CYC(LOOP_CYC)) u_loop_dn (
      .clk    (clk),
      .srst   (srst),
      .bit_en (rx_bit_en),
      .bit_in (rx_one),
      .det    (loop_dn_det)
   );

   // ---------------- tx clock loss ----------------
   logic       tck_s1_ff, tck_s2_ff, tck_s3_ff;
   logic [3:0] tck_idle_ff, nxt_tck_idle;
   logic       tx_clock_loss_flag_ff, nxt_tx_clock_loss_flag;
   logic       tck_edge;

   // third stage only feeds the edge compare, never the first
   assign tck_edge = tck_s2_ff ^ tck_s3_ff;

   always_comb begin
      nxt_tck_idle = tck_idle_ff;
      nxt_tx_clock_loss_flag     = tx_clock_loss_flag_ff;
      if (tck_edge) begin
         nxt_tck_idle = 4'h0;
         nxt_tx_clock_loss_flag     = 1'b0;
      end else if (rx_bit_en) begin
         // timed in receive bits, so it still works with no tx clock at all
         if (tck_idle_ff == 4'(CHAN_BITS - 1)) begin
            nxt_tx_clock_loss_flag = 1'b1;
         end else begin
            nxt_tck_idle = tck_idle_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tck_s1_ff   <= 1'b0;
         tck_s2_ff   <= 1'b0;
         tck_s3_ff   <= 1'b0;
         tck_idle_ff <= 4'h0;
         tx_clock_loss_flag_ff     <= 1'b0;
      end else begin
         tck_s1_ff   <= tx_line_clock;
         tck_s2_ff   <= tck_s1_ff;
         tck_s3_ff   <= tck_s2_ff;
         tck_idle_ff <= nxt_tck_idle;
         tx_clock_loss_flag_ff     <= nxt_tx_clock_loss_flag;
      end
   end

   // ---------------- blue alarm ----------------
   logic        blue_done;
   logic [15:0] blue_cnt;
   logic        ais_ff, nxt_ais;

   t1ad_win_cnt #(.LEN(BLUE_CYC), .CW(16)) u_blue_win (
      .clk   (clk),
      .srst  (srst),
      .run   (1'b1),
      .tick  (1'b1),
      .hit   (rx_bit_en & rx_zero),
      .done  (blue_done),
      .count (blue_cnt)
   );

   always_comb begin
      nxt_ais = ais_ff;
      if (blue_done) begin
         nxt_ais = (blue_cnt <= 16'(AIS_MAX_ZEROS));
      end
   end

   // ---------------- yellow alarm ----------------
   logic       b2_done;
   logic [8:0] b2_cnt;
   logic       esf_done;
   logic [4:0] esf_cnt;
   logic [4:0] esf_run_ff, nxt_esf_run;
   logic       f12_prev_ff, nxt_f12_prev;
   logic       yel_ff, nxt_yel;
   logic       esf_mode;
   logic       fdl_match;

   assign esf_mode  = common_control_two_ff[BIT_ESF_MODE];
   assign fdl_match = frm.fdl_word == ESF_YEL_WORD;

   t1ad_win_cnt #(.LEN(BIT2_WIN), .CW(9)) u_bit2_win (
      .clk   (clk),
      .srst  (srst),
      .run   (1'b1),
      .tick  (frm.bit2_vld),
      .hit   (~frm.bit2),
      .done  (b2_done),
      .count (b2_cnt)
   );

   t1ad_win_cnt #(.LEN(ESF_WIN), .CW(5)) u_esf_win (
      .clk   (clk),
      .srst  (srst),
      .run   (1'b1),
      .tick  (frm.fdl_vld),
      .hit   (fdl_match),
      .done  (esf_done),
      .count (esf_cnt)
   );

   always_comb begin
      nxt_yel      = yel_ff;
      nxt_esf_run  = esf_run_ff;
      nxt_f12_prev = f12_prev_ff;
      if (frm.fdl_vld) begin
         nxt_esf_run = fdl_match ? ((esf_run_ff == 5'(ESF_RUN)) ? esf_run_ff : esf_run_ff + 5'h01) : 5'h00;
      end
      if (frm.fbit12_vld) begin
         nxt_f12_prev = frm.fbit12;
      end
      if (esf_mode) begin
         if (nxt_esf_run == 5'(ESF_RUN)) begin
            nxt_yel = 1'b1;
         end else if (esf_done && esf_cnt <= 5'(ESF_CLR_MAX)) begin
            nxt_yel = 1'b0;
         end
      end else if (rx_control_two_ff[BIT_YEL_F12]) begin
         if (frm.fbit12_vld && frm.fbit12 == f12_prev_ff) begin
            nxt_yel = frm.fbit12;
         end
      end else if (b2_done) begin
         nxt_yel = (b2_cnt >= 9'(BIT2_MIN_ZERO));
      end
   end

   // ---------------- red alarm ----------------
   logic       red_done;
   logic [6:0] red_cnt;
   logic [7:0] zrun_ff, nxt_zrun;
   logic       rcl_ff, nxt_rcl;
   logic       armed_ff, nxt_armed;
   logic       red_start;

   // the first one opens the window and is counted in it
   assign red_start = rcl_ff & ~armed_ff & rx_bit_en & rx_one;

   t1ad_win_cnt #(.LEN(RED_CLR_WIN), .CW(7)) u_red_win (
      .clk   (clk),
      .srst  (srst),
      .run   (armed_ff | red_start),
      .tick  (rx_bit_en),
      .hit   (rx_one),
      .done  (red_done),
      .count (red_cnt)
   );

   always_comb begin
      nxt_zrun  = zrun_ff;
      nxt_rcl   = rcl_ff;
      nxt_armed = armed_ff | red_start;
      if (rx_bit_en) begin
         if (rx_one) begin
            nxt_zrun = 8'h00;
         end else if (zrun_ff == 8'(RED_ZEROS - 1)) begin
            nxt_rcl = 1'b1;
         end else begin
            nxt_zrun = zrun_ff + 8'h01;
         end
      end
      if (red_done) begin
         nxt_armed = 1'b0;
         if (red_cnt >= 7'(RED_CLR_ONES)) begin
            nxt_rcl = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ais_ff      <= 1'b0;
         yel_ff      <= 1'b0;
         esf_run_ff  <= 5'h00;
         f12_prev_ff <= 1'b0;
         zrun_ff     <= 8'h00;
         rcl_ff      <= 1'b0;
         armed_ff    <= 1'b0;
      end else begin
         ais_ff      <= nxt_ais;
         yel_ff      <= nxt_yel;
         esf_run_ff  <= nxt_esf_run;
         f12_prev_ff <= nxt_f12_prev;
         zrun_ff     <= nxt_zrun;
         rcl_ff      <= nxt_rcl;
         armed_ff    <= nxt_armed;
      end
   end

   // ---------------- status, control, port ----------------
   always_comb begin
      events                = 8'h00;
      events[BIT_LOOP_UP]   = loop_up_det;
      events[BIT_LOOP_DOWN] = loop_dn_det;
      events[BIT_TXCLK_LOS] = tx_clock_loss_flag_ff;
      events[BIT_RX_SLIP]   = frm.slip;
      events[BIT_RX_AIS]    = ais_ff;
      events[BIT_RX_REMOTE] = yel_ff;
      events[BIT_RX_SIGLOS] = rcl_ff;
      events[BIT_RX_SYNCLS] = frm.sync_loss;
   end

   assign wr_stat = host.cs & host.wr & (host.addr == ADDR_ALARM_STATUS_ONE);

   always_comb begin
      nxt_irq_mask_one       = irq_mask_one_ff;
      nxt_common_control_one = common_control_one_ff;
      nxt_common_control_two = common_control_two_ff;
      nxt_rx_control_two     = rx_control_two_ff;
      nxt_copy               = copy_ff;
      // a same-cycle event beats the clear
      nxt_latch              = (latch_ff & ~(wr_stat ? host.wdata : 8'h00)) | events;
      if (wr_stat) begin
         nxt_copy = (copy_ff & ~host.wdata) | (latch_ff & host.wdata);
      end
      if (host.cs && host.wr) begin
         case (host.addr)
            ADDR_IRQ_MASK_ONE:    nxt_irq_mask_one = host.wdata;
            ADDR_COMMON_CTRL_ONE: nxt_common_control_one = host.wdata;
            ADDR_COMMON_CTRL_TWO: nxt_common_control_two = host.wdata;
            ADDR_RX_CONTROL_TWO:  nxt_rx_control_two = host.wdata;
            default:              nxt_irq_mask_one = irq_mask_one_ff;
         endcase
      end
      nxt_rdata = rdata_ff;
      if (host.cs && host.rd) begin
         case (host.addr)
            ADDR_ALARM_STATUS_ONE: nxt_rdata = copy_ff;
            ADDR_IRQ_MASK_ONE:     nxt_rdata = irq_mask_one_ff;
            ADDR_COMMON_CTRL_ONE:  nxt_rdata = common_control_one_ff;
            ADDR_COMMON_CTRL_TWO:  nxt_rdata = common_control_two_ff;
            ADDR_RX_CONTROL_TWO:   nxt_rdata = rx_control_two_ff;
            default:               nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         latch_ff              <= RST_BYTE;
         copy_ff               <= RST_BYTE;
         irq_mask_one_ff       <= RST_BYTE;
         common_control_one_ff <= RST_BYTE;
         common_control_two_ff <= RST_BYTE;
         rx_control_two_ff     <= RST_BYTE;
         rdata_ff              <= RST_BYTE;
      end else begin
         latch_ff              <= nxt_latch;
         copy_ff               <= nxt_copy;
         irq_mask_one_ff       <= nxt_irq_mask_one;
         common_control_one_ff <= nxt_common_control_one;
         common_control_two_ff <= nxt_common_control_two;
         rx_control_two_ff     <= nxt_rx_control_two;
         rdata_ff              <= nxt_rdata;
      end
   end

   // ---------------- outputs ----------------
   logic tx_pos_ff, tx_neg_ff, tcl_pin_ff, irq_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_pos_ff  <= 1'b0;
         tx_neg_ff  <= 1'b0;
         tcl_pin_ff <= 1'b0;
         irq_ff     <= 1'b0;
      end else begin
         // loopback keeps both rails so violations go back as received
         tx_pos_ff  <= common_control_one_ff[BIT_REMOTE_LOOP] ? rx_line_pos : tx_data_pos;
         tx_neg_ff  <= common_control_one_ff[BIT_REMOTE_LOOP] ? rx_line_neg : tx_data_neg;
         tcl_pin_ff <= common_control_one_ff[BIT_TXCLK_PIN_EN] & tx_clock_loss_flag_ff;
         irq_ff     <= |(latch_ff & irq_mask_one_ff);
      end
   end

   assign rdata             = rdata_ff;
   assign line_tx_pos       = tx_pos_ff;
   assign line_tx_neg       = tx_neg_ff;
   assign tx_clock_loss_pin = tcl_pin_ff;
   assign irq_out_one       = irq_ff;
endmodule
`default_nettype wire

// >>> verilog/t1ad_pkg.sv
// t1 receive alarm detector: shared constants and carrier types.
// assumes a 125 MHz system clock and a framer on the same clock.
package t1ad_pkg;
   // system clock
   localparam int unsigned CLK_HZ = 125_000_000;

   // register offsets on the parallel port
   localparam logic [7:0] ADDR_ALARM_STATUS_ONE = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK_ONE     = 8'h16;
   localparam logic [7:0] ADDR_COMMON_CTRL_ONE  = 8'h37;
   localparam logic [7:0] ADDR_COMMON_CTRL_TWO  = 8'h38;
   localparam logic [7:0] ADDR_RX_CONTROL_TWO   = 8'h2c;

   // alarm_status_one bit positions
   localparam int unsigned BIT_LOOP_UP   = 7;
   localparam int unsigned BIT_LOOP_DOWN = 6;
   localparam int unsigned BIT_TXCLK_LOS = 5;
   localparam int unsigned BIT_RX_SLIP   = 4;
   localparam int unsigned BIT_RX_AIS    = 3;
   localparam int unsigned BIT_RX_REMOTE = 2;
   localparam int unsigned BIT_RX_SIGLOS = 1;
   localparam int unsigned BIT_RX_SYNCLS = 0;

   // control bit positions
   localparam int unsigned BIT_TXCLK_PIN_EN = 6; // common_control_one
   localparam int unsigned BIT_REMOTE_LOOP  = 4; // common_control_one
   localparam int unsigned BIT_ESF_MODE     = 3; // common_control_two
   localparam int unsigned BIT_YEL_F12      = 2; // rx_control_two

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // timing: times in their own unit, counts derived
   localparam int unsigned BLUE_WIN_MS  = 3;
   localparam int unsigned BLUE_WIN_CYC = (CLK_HZ / 1000) * BLUE_WIN_MS;
   localparam int unsigned LOOP_INT_MS  = 48;
   localparam int unsigned LOOP_INT_CYC = (CLK_HZ / 1000) * LOOP_INT_MS;
   localparam int unsigned CHAN_BITS    = 8;   // one channel time, in rx bits

   // alarm criteria
   localparam int unsigned AIS_MAX_ZEROS = 5;
   localparam int unsigned BIT2_WIN      = 256;
   localparam int unsigned BIT2_MIN_ZERO = 254;
   localparam int unsigned ESF_RUN       = 16;
   localparam int unsigned ESF_WIN       = 16;
   localparam int unsigned ESF_CLR_MAX   = 14;
   localparam logic [15:0] ESF_YEL_WORD  = 16'h00ff;
   localparam int unsigned RED_ZEROS     = 192;
   localparam int unsigned RED_CLR_WIN   = 112;
   localparam int unsigned RED_CLR_ONES  = 14;
   localparam int unsigned LOOP_UP_LEN   = 5;
   localparam int unsigned LOOP_DN_LEN   = 3;

   // framer side indications
   typedef struct packed {
      logic        sync_loss;
      logic        slip;
      logic        bit2_vld;
      logic        bit2;
      logic        fbit12_vld;
      logic        fbit12;
      logic        fdl_vld;
      logic [15:0] fdl_word;
   } t1ad_frm_t;

   // host parallel port request
   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } t1ad_host_t;
endpackage

// >>> verilog/t1ad_win_cnt.sv
// fixed-length window counter: counts hits over len ticks.
// assumes tick and hit come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module t1ad_win_cnt
   import t1ad_pkg::*;
#(
   parameter int unsigned LEN = 256,
   parameter int unsigned CW  = 16
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          srst,
   // window control
   input  wire logic          run,
   input  wire logic          tick,
   input  wire logic          hit,
   // result
   output logic               done,
   output logic [CW-1:0]      count
);
   localparam logic [31:0] LAST = 32'(LEN - 1);

   logic [31:0]   pos_ff, nxt_pos;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic          done_ff, nxt_done;
   logic [CW-1:0] cnt_ff_out, nxt_cnt_out;

   always_comb begin
      nxt_pos     = pos_ff;
      nxt_cnt     = cnt_ff;
      nxt_done    = 1'b0;
      nxt_cnt_out = cnt_ff_out;
      if (!run) begin
         nxt_pos = '0;
         nxt_cnt = '0;
      end else if (tick) begin
         if (pos_ff == LAST) begin
            nxt_done    = 1'b1;
            nxt_cnt_out = cnt_ff + CW'(hit);
            nxt_pos     = '0;
            nxt_cnt     = '0;
         end else begin
            nxt_pos = pos_ff + 32'd1;
            nxt_cnt = cnt_ff + CW'(hit);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pos_ff     <= '0;
         cnt_ff     <= '0;
         done_ff    <= 1'b0;
         cnt_ff_out <= '0;
      end else begin
         pos_ff     <= nxt_pos;
         cnt_ff     <= nxt_cnt;
         done_ff    <= nxt_done;
         cnt_ff_out <= nxt_cnt_out;
      end
   end

   assign done  = done_ff;
   assign count = cnt_ff_out;
endmodule
`default_nettype wire

// >>> verilog/t1ad_loop_det.sv
// repeating loop code detector: one '1' in every len-bit window.
// integrates over a fixed cycle count, tolerant of scattered bit errors.
`timescale 1ns/1ps
`default_nettype none
module t1ad_loop_det
   import t1ad_pkg::*;
#(
   parameter int unsigned P       = 5,
   parameter int unsigned INT_CYC = LOOP_INT_CYC
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // received bits
   input  wire logic bit_en,
   input  wire logic bit_in,
   // detection level
   output logic      det
);
   localparam logic [31:0] LAST = 32'(INT_CYC - 1);

   logic [P-1:0] sh_ff, nxt_sh;
   logic [31:0]  tim_ff, nxt_tim;
   logic [31:0]  bits_ff, nxt_bits;
   logic [31:0]  bad_ff, nxt_bad;
   logic         det_ff, nxt_det;
   logic [7:0]   ones;

   always_comb begin
      nxt_sh = bit_en ? {sh_ff[P-2:0], bit_in} : sh_ff;
      ones   = 8'h00;
      for (int i = 0; i < P; i++) begin
         ones = ones + 8'(nxt_sh[i]);
      end
      nxt_tim  = tim_ff + 32'd1;
      nxt_bits = bits_ff + 32'(bit_en);
      nxt_bad  = bad_ff + 32'(bit_en && ones != 8'h01);
      nxt_det  = det_ff;
      if (tim_ff == LAST) begin
         // fewer than one bad window in eight covers 1e-2 errors smeared over p windows
         nxt_det  = (bits_ff != 32'd0) && ({bad_ff[28:0], 3'b000} < bits_ff);
         nxt_tim  = '0;
         nxt_bits = '0;
         nxt_bad  = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sh_ff   <= '0;
         tim_ff  <= '0;
         bits_ff <= '0;
         bad_ff  <= '0;
         det_ff  <= 1'b0;
      end else begin
         sh_ff   <= nxt_sh;
         tim_ff  <= nxt_tim;
         bits_ff <= nxt_bits;
         bad_ff  <= nxt_bad;
         det_ff  <= nxt_det;
      end
   end

   assign det = det_ff;
endmodule
`default_nettype wire

// >>> testbench/t1ad_alarm_monitor.sv
// checker on the alarm detector's ports.
// assumes a bind to t1ad_alarm_top.
`timescale 1ns/1ps
`default_nettype none
module t1ad_alarm_monitor
   import t1ad_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // line side
   input wire logic       rx_bit_en,
   input wire logic       rx_line_pos,
   input wire logic       rx_line_neg,
   input wire logic       tx_data_pos,
   input wire t1ad_frm_t  frm,
   // host side and outputs
   input wire t1ad_host_t host,
   input wire logic [7:0] rdata,
   input wire logic       line_tx_pos,
   input wire logic       line_tx_neg,
   input wire logic       tx_clock_loss_pin,
   input wire logic       irq_out_one
);
   logic [7:0] mask_ff;
   logic [7:0] ctl_ff;
   logic [7:0] zrun_ff;
   wire logic  wr_any = host.cs & host.wr;
   always_ff @(posedge clk) begin
      if (srst) begin
         {mask_ff, ctl_ff, zrun_ff} <= '0;
      end else begin
         if (wr_any && host.addr == ADDR_IRQ_MASK_ONE) mask_ff <= host.wdata;
         if (wr_any && host.addr == ADDR_COMMON_CTRL_ONE) ctl_ff <= host.wdata;
         if (rx_bit_en) zrun_ff <= (rx_line_pos | rx_line_neg) ? 8'h00 : zrun_ff + {7'h0, zrun_ff != 8'hff};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_quiet_hi; !wr_any ##1 (!wr_any && irq_out_one); endsequence
   sequence s_no_mask; mask_ff == 8'h00 ##1 mask_ff == 8'h00; endsequence
   property p_lb_on;
      ctl_ff[BIT_REMOTE_LOOP] |=> line_tx_pos == $past(rx_line_pos) && line_tx_neg == $past(rx_line_neg);
   endproperty
   property p_lb_off; !ctl_ff[BIT_REMOTE_LOOP] |=> line_tx_pos == $past(tx_data_pos); endproperty
   property p_pin_off; !ctl_ff[BIT_TXCLK_PIN_EN] |=> !tx_clock_loss_pin; endproperty
   property p_irq_masked; s_no_mask |=> !irq_out_one; endproperty
   property p_red_irq; mask_ff[BIT_RX_SIGLOS] && zrun_ff == 8'hc0 |-> ##[1:6] irq_out_one; endproperty
   property p_slip_irq; frm.slip && mask_ff[BIT_RX_SLIP] |-> ##[1:3] irq_out_one; endproperty
   property p_sync_irq; frm.sync_loss && mask_ff[BIT_RX_SYNCLS] |-> ##[1:3] irq_out_one; endproperty
   property p_rdata_hold; !(host.cs && host.rd) |=> $stable(rdata); endproperty
   property p_latch_hold; s_quiet_hi |=> irq_out_one; endproperty
   a_lb_on: assert property (p_lb_on) else $error("loop out bad");
   a_lb_off: assert property (p_lb_off) else $error("line out bad");
   a_pin_off: assert property (p_pin_off) else $error("pin not off");
   a_irq_masked: assert property (p_irq_masked) else $error("masked irq");
   a_red_irq: assert property (p_red_irq) else $error("no red irq");
   a_slip_irq: assert property (p_slip_irq) else $error("no slip irq");
   a_sync_irq: assert property (p_sync_irq) else $error("no sync irq");
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
   a_latch_hold: assert property (p_latch_hold) else $error("irq dropped");
endmodule
`default_nettype wire

// >>> testbench/t1ad_line_model.sv
// far-end model: one ami bit per four clocks.
// assumes period 0 means all zeros.
`timescale 1ns/1ps
`default_nettype none
module t1ad_line_model (
   // clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // pattern
   input wire logic [3:0] period,
   // line
   output logic           bit_en,
   output logic           pos,
   output logic           neg
);
   logic [1:0] div_ff;
   logic [3:0] ph_ff;
   logic       pol_ff, en_ff, p_ff, n_ff;
   logic       mark;
   assign mark = (period != 4'h0) && (ph_ff == 4'h0);
   assign bit_en = ~srst & en_ff;
   assign pos = ~srst & p_ff;
   assign neg = ~srst & n_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         {div_ff, ph_ff, pol_ff, en_ff, p_ff, n_ff} <= '0;
      end else begin
         div_ff <= div_ff + 2'h1;
         en_ff <= (div_ff == 2'h3);
         if (div_ff == 2'h3) begin
            ph_ff <= (ph_ff + 4'h1 >= period) ? 4'h0 : ph_ff + 4'h1;
            pol_ff <= pol_ff ^ mark;
            p_ff <= mark & ~pol_ff;
            n_ff <= mark & pol_ff;
         end else begin
            // rails carry no data between strobes
            p_ff <= ~p_ff;
            n_ff <= ~n_ff;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/t1ad_alarm_top_bench.sv
// bench for the alarm detector, short windows.
// assumes the far-end model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module t1ad_alarm_top_bench;
   import t1ad_pkg::*;
   localparam int unsigned BL = 2000;
   localparam int unsigned LC = 500;
   localparam logic [7:0] SR = ADDR_ALARM_STATUS_ONE;
   logic clk, srst, txc, txc_run, rx_en, rxp, rxn, ltp, pin, irq;
   logic [3:0] period;
   logic [7:0] rdata, v;
   t1ad_frm_t  frm;
   t1ad_host_t host;
   int fails, n_compared;
   t1ad_line_model u_far (.clk(clk), .srst(srst), .period(period), .bit_en(rx_en), .pos(rxp), .neg(rxn));
   t1ad_alarm_top #(.BLUE_CYC(BL), .LOOP_CYC(LC)) uut (.clk(clk), .srst(srst), .rx_bit_en(rx_en),
      .rx_line_pos(rxp), .rx_line_neg(rxn), .tx_line_clock(txc), .tx_data_pos(txc), .tx_data_neg(1'b0),
      .frm(frm), .host(host), .rdata(rdata), .line_tx_pos(ltp), .line_tx_neg(), .tx_clock_loss_pin(pin),
      .irq_out_one(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (txc_run) txc <= ~txc;
   task automatic end_of_test;
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) host <= {1'b1, 1'b1, 1'b0, a, d};
      @(posedge clk) host <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk) host <= {1'b1, 1'b0, 1'b1, a, 8'h00};
      @(posedge clk) host <= '0;
      #1 v = rdata;
   endtask
   task automatic sr(input logic [7:0] m, input logic [7:0] e);
      wr(SR, m);
      rd(SR);
      chk("alarm_status_one", e, v & m);
   endtask
   task automatic fr(input logic [7:0] m, input logic [7:0] e);
      wr(SR, m);
      sr(m, e);
   endtask
   task automatic pat(input logic [3:0] p, input int n);
      @(posedge clk) period <= p;
      cyc(n);
   endtask
   task automatic wait_sig(input int w, input logic e);
      for (int i = 0; i < 300 && (w == 0 ? pin : irq) !== e; i++) @(negedge clk);
      chk(w == 0 ? "tx_clock_loss_pin" : "irq_out_one", {7'h0, e}, {7'h0, w == 0 ? pin : irq});
      if (fails != 0) end_of_test;
   endtask
   task automatic fp(input int k, input int n, input int every);
      logic b;
      for (int i = 0; i < n; i++) begin
         b = (every != 0) && (i % every == 0);
         @(posedge clk) {frm.bit2_vld, frm.fbit12_vld, frm.fdl_vld} <= {k == 0, k == 1, k == 2};
         frm.bit2 <= b;
         frm.fbit12 <= b;
         frm.fdl_word <= b ? 16'h0000 : ESF_YEL_WORD;
         @(posedge clk) {frm.bit2_vld, frm.fbit12_vld, frm.fdl_vld} <= 3'b000;
      end
      // the latch lags the last strobe by up to three edges
      cyc(3);
   endtask
   task automatic t_blue;
      sr(8'hff, 8'h00);
      cyc(2 * BL + 20);
      sr(8'h08, 8'h08);
   endtask
   task automatic t_red;
      wr(ADDR_IRQ_MASK_ONE, 8'h02);
      pat(4'h0, 820);
      sr(8'h02, 8'h02);
      wait_sig(1, 1'b1);
      pat(4'h9, 900);
      fr(8'h02, 8'h02);
      pat(4'h8, 1000);
      fr(8'h02, 8'h00);
      wr(ADDR_IRQ_MASK_ONE, 8'h00);
      cyc(2 * BL + 20);
      fr(8'h08, 8'h00);
   endtask
   task automatic t_loop;
      pat(4'h5, 3 * LC);
      fr(8'hc0, 8'h80);
      pat(4'h3, 3 * LC);
      fr(8'hc0, 8'h40);
      pat(4'h1, 0);
   endtask
   task automatic t_yellow;
      fp(0, 256, 128);
      sr(8'h04, 8'h04);
      fp(0, 256, 86);
      fr(8'h04, 8'h00);
      wr(ADDR_RX_CONTROL_TWO, 8'h04);
      fp(1, 2, 1);
      sr(8'h04, 8'h04);
      fp(1, 2, 0);
      fr(8'h04, 8'h00);
      wr(ADDR_RX_CONTROL_TWO, 8'h00);
      wr(ADDR_COMMON_CTRL_TWO, 8'h08);
      fp(2, 16, 0);
      sr(8'h04, 8'h04);
      fp(2, 32, 8);
      fr(8'h04, 8'h00);
      wr(ADDR_COMMON_CTRL_TWO, 8'h00);
   endtask
   task automatic t_txclk;
      wr(ADDR_COMMON_CTRL_ONE, 8'h50);
      @(posedge clk) txc_run <= 1'b0;
      wait_sig(0, 1'b1);
      sr(8'h20, 8'h20);
      @(posedge clk) txc_run <= 1'b1;
      wait_sig(0, 1'b0);
      wr(ADDR_COMMON_CTRL_ONE, 8'h10);
      @(posedge clk) txc_run <= 1'b0;
      cyc(100);
      @(negedge clk) chk("tx_clock_loss_pin", 8'h00, {7'h0, pin});
      @(posedge clk) txc_run <= 1'b1;
      wr(ADDR_COMMON_CTRL_ONE, 8'h00);
   endtask
   task automatic t_irq;
      wr(ADDR_IRQ_MASK_ONE, 8'h11);
      wr(SR, 8'h11);
      @(posedge clk) frm.slip <= 1'b1;
      @(posedge clk) frm.slip <= 1'b0;
      wait_sig(1, 1'b1);
      sr(8'h10, 8'h10);
      wr(SR, 8'h00);
      rd(SR);
      chk("alarm_status_one", 8'h10, v & 8'h10);
      sr(8'h10, 8'h00);
      wait_sig(1, 1'b0);
      @(posedge clk) frm.sync_loss <= 1'b1;
      wait_sig(1, 1'b1);
      wr(ADDR_IRQ_MASK_ONE, 8'h00);
      wait_sig(1, 1'b0);
      sr(8'h01, 8'h01);
      @(posedge clk) frm.sync_loss <= 1'b0;
      rd(8'h3f);
      chk("unmapped_read", 8'h00, v);
   endtask
   initial begin
      srst = 1'b1;
      txc = 1'b0;
      txc_run = 1'b1;
      period = 4'h1;
      frm = '0;
      host = '0;
      fails = 0;
      n_compared = 0;
      cyc(2);
      srst <= 1'b0;
      t_blue;
      t_red;
      t_loop;
      t_yellow;
      t_txclk;
      t_irq;
      end_of_test;
   end
endmodule
bind t1ad_alarm_top t1ad_alarm_monitor u_mon (.clk(clk), .srst(srst), .rx_bit_en(rx_bit_en),
   .rx_line_pos(rx_line_pos), .rx_line_neg(rx_line_neg), .tx_data_pos(tx_data_pos), .frm(frm),
   .host(host), .rdata(rdata), .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg),
   .tx_clock_loss_pin(tx_clock_loss_pin),
   .irq_out_one(irq_out_one));
`default_nettype wire
